// ===== dprs_dbg.sv
// External debugger model issuing single reads.
// Assumes a fixed one-cycle answer on the read port.
`timescale 1ns/10ps
module dprs_dbg (
  // Clock
  input wire mclk,
  // Read port
  output reg rd_req,
  output reg [11:0] addr,
  input wire rd_valid,
  input wire [31:0] rd_data,
  input wire rd_error
);
  initial begin
    rd_req = 1'b0;
    addr = 12'h0000;
  end
  // Address is inverted once released; ok means answered without error
  task read(input [11:0] a, output [31:0] d, output ok);
    begin
      @(negedge mclk);
      rd_req = 1'b1;
      addr = a;
      @(negedge mclk);
      ok = rd_valid & ~rd_error;
      d = rd_data;
      rd_req = 1'b0;
      addr = ~a;
    end
  endtask
endmodule // dprs_dbg

// ===== dprs_defs.vh
// Constants for the debug power and reset status register block.
// Assumes inclusion by bare name from the design files.
`ifndef DPRS_DEFS_VH
`define DPRS_DEFS_VH
`define DPRS_REG_OFFSET 12'h0314
`define DPRS_ADDR_W 12
`define DPRS_BIT_POWERED 0
`define DPRS_BIT_STICKY_PD 1
`define DPRS_BIT_IN_RESET 2
`define DPRS_BIT_STICKY_RST 3
`define DPRS_BIT_HALTED 4
`define DPRS_BIT_OS_LOCK 5
`define DPRS_BIT_DOUBLE_LOCK 6
`define DPRS_BIT_ACCESS_ERR 8
`define DPRS_BIT_PERFMON_ERR 9
`define DPRS_BIT_RESTART_ERR 10
`define DPRS_STICKY_W 3
`define DPRS_RST_STICKY_PD 1'b1
`define DPRS_RST_STICKY_RST 1'b1
`endif

// ===== dprs_status.v
// Debug power and reset status register, read from the external debug port.
// Assumes core state inputs are synchronous to mclk; one read per rd_req pulse.
// Function
// - Double-lock bit reads 1 only when double lock active and core powered.
// - Powered, double locked, no debug power domain: fixed choice of powerup/lock vs zero reporting.
// - OS-lock bit mirrors the system-register lock status bit.
// - Halted bit is 1 in debug state, 0 otherwise.
// - Sticky reset reads 1 if in reset or reset since last read.
// - Warm reset sets sticky reset to 1.
// - Sticky reset is read-clear, read-only under software lock, unknown if locked.
// - Read clears sticky reset only when powered, unlocked, not in reset.
// - Reset bit reads 1 while non-debug logic is held in reset.
// - Sticky powerdown reads 1 when core debug register state is lost.
// - Cold reset sets sticky powerdown to 1.
// - Under double lock with later debug level, sticky powerdown reads 0.
// - Sticky powerdown reads zero when unpowered without debug power domain.
// - Powered, unlocked read clears sticky error and powerdown bits.
// - Unpowered without debug domain, sticky reset and error bits reset on power-up.
// - Unpowered read without debug domain leaves sticky powerdown unchanged.
// - Powerup bit is 1 when powered and not double locked; under double lock it reads LOCK_REPORTS_POWERED, or 1 with a separate debug power domain.
// - With separate debug power domain, powerup reads one on every powered read.
// - Register at 0x314, read-only; error when unpowered with debug domain.
// - Read-caused clearing is applied after pre-clear value is returned.
`timescale 1ns/10ps
`include "dprs_defs.vh"
module dprs_status #(
  parameter SEPARATE_DEBUG_POWER_DOMAIN = 1'b0,
  parameter DOUBLE_LOCK_FEATURE = 1'b1,
  parameter LATER_DEBUG_LEVEL = 1'b1,
  parameter LOCK_REPORTS_POWERED = 1'b0
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Core resets (one-cycle pulses)
  input wire core_cold_reset,
  input wire core_warm_reset,
  // Core state levels
  input wire core_power_state,
  input wire double_lock_state,
  input wire software_lock_state,
  input wire os_lock_status_sysreg,
  input wire core_halted,
  input wire core_in_reset,
  input wire core_power_lost,
  // Sticky error events
  input wire [`DPRS_STICKY_W-1:0] sticky_err_event,
  // External debug port
  input wire rd_req,
  input wire wr_req,
  input wire [`DPRS_ADDR_W-1:0] addr,
  output reg rd_valid,
  output reg [31:0] rd_data,
  output reg rd_error
);
  // Access classes of the register as seen from the debug port
  localparam ACC_OPEN = 2'b00;
  localparam ACC_LOCKED = 2'b01;
  localparam ACC_OFF = 2'b10;
  localparam ACC_ERROR = 2'b11;

  // Decode and qualifiers
  wire locked;
  wire powered;
  wire hit;
  wire reg_rd;
  wire unpowered_nodom;
  wire unpowered_dom;
  wire clr_ok;
  wire clr_sticky_rst;
  wire power_up_edge;
  wire restore_on_power;
  reg pwr_q;

  // Sticky flag controls and state
  wire sticky_rst_set;
  wire sticky_rst_clear;
  wire sticky_pd_set;
  wire sticky_pd_clear;
  wire err_clear;
  wire sticky_rst_flag;
  wire sticky_pd_flag;
  wire [`DPRS_STICKY_W-1:0] err_flag;

  // Field values offered to a read
  reg [1:0] acc;
  reg fld_powered;
  reg fld_sticky_pd;
  reg fld_in_reset;
  reg fld_sticky_rst;
  reg fld_halted;
  reg fld_os_lock;
  reg fld_double_lock;
  reg [`DPRS_STICKY_W-1:0] fld_err;
  reg [31:0] next_rd_data;
  reg next_err;
  reg [31:0] next_word;

  assign locked = DOUBLE_LOCK_FEATURE & double_lock_state;
  assign powered = core_power_state;
  assign hit = (addr == `DPRS_REG_OFFSET);
  assign reg_rd = rd_req & hit;
  assign unpowered_nodom = ~SEPARATE_DEBUG_POWER_DOMAIN & ~powered;
  assign unpowered_dom = SEPARATE_DEBUG_POWER_DOMAIN & ~powered;

  // Read with core powered and lock inactive triggers clearing
  assign clr_ok = reg_rd & powered & ~locked;

  // Sticky reset survives a read while reset is live or software lock holds
  assign clr_sticky_rst = clr_ok & ~core_in_reset & ~software_lock_state;

  // Flags lost with the core domain are rebuilt when it returns
  assign restore_on_power = power_up_edge & ~SEPARATE_DEBUG_POWER_DOMAIN;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= powered;
    end
  end
  assign power_up_edge = powered & ~pwr_q;

  assign sticky_rst_set = core_warm_reset | core_in_reset | restore_on_power;
  assign sticky_rst_clear = clr_sticky_rst;
  assign sticky_pd_set = core_cold_reset | core_power_lost;
  // Only a powered read reaches clr_ok, so an unpowered read keeps the flag
  assign sticky_pd_clear = clr_ok;
  assign err_clear = clr_ok | core_cold_reset | restore_on_power;

  // Sticky reset: set by warm reset or while in reset; cleared after read
  dprs_sticky #(
    .RESET_VAL(`DPRS_RST_STICKY_RST)
  ) u_sticky_rst (
    .mclk(mclk),
    .reset_n(reset_n),
    .set(sticky_rst_set),
    .clear(sticky_rst_clear),
    .flag(sticky_rst_flag)
  );

  // Sticky powerdown: set by cold reset or loss; never cleared while unpowered
  dprs_sticky #(
    .RESET_VAL(`DPRS_RST_STICKY_PD)
  ) u_sticky_pd (
    .mclk(mclk),
    .reset_n(reset_n),
    .set(sticky_pd_set),
    .clear(sticky_pd_clear),
    .flag(sticky_pd_flag)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `DPRS_STICKY_W; gi = gi + 1) begin : g_err
      dprs_sticky #(
        .RESET_VAL(1'b0)
      ) u_err (
        .mclk(mclk),
        .reset_n(reset_n),
        .set(sticky_err_event[gi]),
        .clear(err_clear),
        .flag(err_flag[gi])
      );
    end
  endgenerate

  // Classify the current access condition
  always @* begin
    if (unpowered_dom) begin
      acc = ACC_ERROR;
    end else if (!powered) begin
      acc = ACC_OFF;
    end else if (locked) begin
      acc = ACC_LOCKED;
    end else begin
      acc = ACC_OPEN;
    end
  end

  // Powerup and double-lock fields
  always @* begin
    fld_powered = 1'b0;
    fld_double_lock = 1'b0;
    case (acc)
      ACC_OPEN: begin
        fld_powered = 1'b1;
        fld_double_lock = 1'b0;
      end
      ACC_LOCKED: begin
        fld_powered = LOCK_REPORTS_POWERED;
        fld_double_lock = LOCK_REPORTS_POWERED;
      end
      ACC_OFF: begin
        fld_powered = 1'b0;
        fld_double_lock = 1'b0;
      end
      default: begin
        fld_powered = 1'b0;
        fld_double_lock = 1'b0;
      end
    endcase
    if (SEPARATE_DEBUG_POWER_DOMAIN) begin
      fld_powered = 1'b1;
    end
  end

  // Sticky powerdown field
  always @* begin
    fld_sticky_pd = 1'b0;
    case (acc)
      ACC_OPEN: begin
        fld_sticky_pd = sticky_pd_flag;
      end
      ACC_LOCKED: begin
        fld_sticky_pd = LATER_DEBUG_LEVEL ? 1'b0 : sticky_pd_flag;
      end
      ACC_OFF: begin
        fld_sticky_pd = 1'b0;
      end
      default: begin
        fld_sticky_pd = 1'b0;
      end
    endcase
  end

  // Sticky reset and live reset fields
  always @* begin
    fld_sticky_rst = 1'b0;
    fld_in_reset = 1'b0;
    case (acc)
      ACC_OPEN: begin
        fld_sticky_rst = sticky_rst_flag | core_in_reset;
        fld_in_reset = core_in_reset;
      end
      ACC_LOCKED: begin
        fld_sticky_rst = sticky_rst_flag;
        fld_in_reset = core_in_reset;
      end
      ACC_OFF: begin
        fld_sticky_rst = 1'b0;
        fld_in_reset = 1'b0;
      end
      default: begin
        fld_sticky_rst = 1'b0;
        fld_in_reset = 1'b0;
      end
    endcase
  end

  // Halted and OS lock mirror fields
  always @* begin
    fld_halted = 1'b0;
    fld_os_lock = 1'b0;
    case (acc)
      ACC_OPEN: begin
        fld_halted = core_halted;
        fld_os_lock = os_lock_status_sysreg;
      end
      ACC_LOCKED: begin
        fld_halted = core_halted;
        fld_os_lock = os_lock_status_sysreg;
      end
      ACC_OFF: begin
        fld_halted = 1'b0;
        fld_os_lock = 1'b0;
      end
      default: begin
        fld_halted = 1'b0;
        fld_os_lock = 1'b0;
      end
    endcase
  end

  // Sticky error fields are only shown when the register is open
  always @* begin
    fld_err = {`DPRS_STICKY_W{1'b0}};
    case (acc)
      ACC_OPEN: begin
        fld_err = err_flag;
      end
      default: begin
        fld_err = {`DPRS_STICKY_W{1'b0}};
      end
    endcase
  end

  // Compose pre-clear value; clearing lands on the same edge as capture
  always @* begin
    next_rd_data = 32'h0000_0000;
    next_err = (acc == ACC_ERROR);
    next_rd_data[`DPRS_BIT_POWERED] = fld_powered;
    next_rd_data[`DPRS_BIT_STICKY_PD] = fld_sticky_pd;
    next_rd_data[`DPRS_BIT_IN_RESET] = fld_in_reset;
    next_rd_data[`DPRS_BIT_STICKY_RST] = fld_sticky_rst;
    next_rd_data[`DPRS_BIT_HALTED] = fld_halted;
    next_rd_data[`DPRS_BIT_OS_LOCK] = fld_os_lock;
    next_rd_data[`DPRS_BIT_DOUBLE_LOCK] = fld_double_lock;
    next_rd_data[`DPRS_BIT_ACCESS_ERR] = fld_err[0];
    next_rd_data[`DPRS_BIT_PERFMON_ERR] = fld_err[1];
    next_rd_data[`DPRS_BIT_RESTART_ERR] = fld_err[2];
    if (next_err) begin
      next_rd_data = 32'h0000_0000;
    end
  end

  // Word handed back: other addresses and refused reads give zero
  always @* begin
    next_word = 32'h0000_0000;
    if (reg_rd && !next_err) begin
      next_word = next_rd_data;
    end
  end

  // Reads capture old value; writes are ignored; other addresses read zero
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h0000_0000;
      rd_error <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      rd_error <= reg_rd & next_err;
      rd_data <= next_word;
    end
  end
endmodule // dprs_status

// ===== dprs_status_monitor.sv
// Checker for the status register read port.
// Assumes it is bound onto each dprs_status instance.
`timescale 1ns/10ps
module dprs_mon (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Core levels
  input wire core_power_state,
  input wire double_lock_state,
  input wire core_halted,
  input wire core_in_reset,
  // Read port
  input wire rd_req,
  input wire [11:0] addr,
  input wire rd_valid,
  input wire [31:0] rd_data,
  input wire rd_error
);
  wire hit = rd_req && addr == 12'h0314 && core_power_state;
  wire hit_ul = hit && !double_lock_state;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_answer_next: assert property (rd_req |=> rd_valid) else $error("no answer");
  a_valid_cause: assert property (rd_valid |-> $past(rd_req)) else $error("stray answer");
  a_no_error: assert property (rd_valid && rd_error |-> !$past(core_power_state))
    else $error("error response while powered");
  a_halted_bit: assert property (hit |=> rd_data[4] == $past(core_halted))
    else $error("halted bit");
  a_reset_bit: assert property (hit_ul |=> rd_data[2] == $past(core_in_reset))
    else $error("reset bit");
  a_sr_live: assert property (hit_ul && core_in_reset |=> rd_data[3])
    else $error("sticky reset");
  a_pu_bit: assert property (hit |=> rd_data[0] == !$past(double_lock_state))
    else $error("powerup bit");
  a_lock_pairing: assert property (hit && double_lock_state |=> rd_data[6] == rd_data[0])
    else $error("double lock bit");
endmodule // dprs_mon

bind dprs_status dprs_mon dprs_mon_i (.mclk, .reset_n, .core_power_state,
  .double_lock_state, .core_halted, .core_in_reset, .rd_req, .addr, .rd_valid,
  .rd_data, .rd_error);

// ===== dprs_status_tb_top.sv
// Bench for the status register: level table, then sticky cases.
// Assumes the debugger model issues every read.
`timescale 1ns/10ps
module dprs_status_tb_top;
  reg mclk = 0;
  reg reset_n = 0;
  reg [5:0] lv = 6'h20;
  reg [5:0] ev = 6'h00;
  reg wr_req = 0;
  wire rd_req, rd_valid, rd_error;
  wire [11:0] addr;
  wire [31:0] rd_data;
  wire rd_req2, rd_valid2, rd_error2;
  wire [11:0] addr2;
  wire [31:0] rd_data2;
  reg [31:0] d;
  reg ok;
  integer n_fail = 0, n_checks = 0, i;
  reg [37:0] tbl [0:5];
  initial forever #2.5 mclk = ~mclk;
  dprs_status dprs_status_i (.mclk(mclk), .reset_n(reset_n), .core_cold_reset(ev[5]),
    .core_warm_reset(ev[4]), .core_power_lost(ev[3]), .sticky_err_event(ev[2:0]),
    .core_power_state(lv[5]), .double_lock_state(lv[4]), .os_lock_status_sysreg(lv[3]),
    .core_halted(lv[2]), .core_in_reset(lv[1]), .software_lock_state(lv[0]),
    .rd_req(rd_req), .wr_req(wr_req), .addr(addr), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_error(rd_error));
  dprs_dbg dprs_dbg_i (.mclk(mclk), .rd_req(rd_req), .addr(addr), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_error(rd_error));
  // Second copy with its own debug power domain
  dprs_status #(.SEPARATE_DEBUG_POWER_DOMAIN(1'b1)) dprs_status_dom_i (.mclk(mclk),
    .reset_n(reset_n), .core_cold_reset(ev[5]), .core_warm_reset(ev[4]),
    .core_power_lost(ev[3]), .sticky_err_event(ev[2:0]), .core_power_state(lv[5]),
    .double_lock_state(lv[4]), .os_lock_status_sysreg(lv[3]), .core_halted(lv[2]),
    .core_in_reset(lv[1]), .software_lock_state(lv[0]), .rd_req(rd_req2), .wr_req(wr_req),
    .addr(addr2), .rd_valid(rd_valid2), .rd_data(rd_data2), .rd_error(rd_error2));
  dprs_dbg dprs_dbg_dom_i (.mclk(mclk), .rd_req(rd_req2), .addr(addr2),
    .rd_valid(rd_valid2), .rd_data(rd_data2), .rd_error(rd_error2));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      dprs_dbg_i.read(a, d, ok);
      chk({31'h0, ok}, 32'h0000_0001);
      chk(d, exp);
    end
  endtask
  task pulse(input [5:0] p);
    begin
      @(negedge mclk);
      ev = p;
      @(negedge mclk);
      ev = 6'h00;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    // Levels {power, dlock, oslock, halted, in_reset, swlock}, then read value
    tbl[0] = 38'h20_0000_0001;
    tbl[1] = 38'h24_0000_0011;
    tbl[2] = 38'h28_0000_0021;
    tbl[3] = 38'h30_0000_0000;
    tbl[4] = 38'h00_0000_0000;
    tbl[5] = 38'h22_0000_000d;
    repeat (6) @(negedge mclk);
    reset_n = 1;
    rd(12'h0314, 32'h0000_000b);
    rd(12'h0314, 32'h0000_0001);
    for (i = 0; i < 6; i = i + 1) begin
      lv = tbl[i][37:32];
      rd(12'h0314, tbl[i][31:0]);
    end
    lv = 6'h20;
    rd(12'h0314, 32'h0000_0009);
    rd(12'h0314, 32'h0000_0001);
    pulse(6'h10);
    lv = 6'h21;
    rd(12'h0314, 32'h0000_0009);
    rd(12'h0314, 32'h0000_0009);
    lv = 6'h20;
    rd(12'h0314, 32'h0000_0009);
    pulse(6'h0f);
    rd(12'h0314, 32'h0000_0703);
    pulse(6'h20);
    rd(12'h0314, 32'h0000_0003);
    pulse(6'h08);
    lv = 6'h30;
    rd(12'h0314, 32'h0000_0000);
    lv = 6'h00;
    rd(12'h0314, 32'h0000_0000);
    lv = 6'h20;
    rd(12'h0314, 32'h0000_000b);
    rd(12'h0310, 32'h0000_0000);
    wr_req = 1;
    rd(12'h0314, 32'h0000_0001);
    wr_req = 0;
    @(negedge mclk);
    reset_n = 0;
    @(negedge mclk);
    chk(rd_data, 32'h0000_0000);
    chk({31'h0, rd_valid}, 32'h0000_0000);
    reset_n = 1;
    rd(12'h0314, 32'h0000_000b);
    dprs_dbg_dom_i.read(12'h0314, d, ok);
    chk({31'h0, ok}, 32'h0000_0001);
    chk(d, 32'h0000_000b);
    lv = 6'h00;
    dprs_dbg_dom_i.read(12'h0314, d, ok);
    chk({31'h0, ok}, 32'h0000_0000);
    chk(d, 32'h0000_0000);
    results;
  end
endmodule // dprs_status_tb_top

// ===== dprs_sticky.v
// Sticky event flag with read-clear; the set wins over the clear.
// Assumes set and clear are synchronous to mclk.
`timescale 1ns/10ps
module dprs_sticky #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Control
  input wire set,
  input wire clear,
  // State
  output reg flag
);
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= RESET_VAL;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule // dprs_sticky
